// >>> logic/sei_defines.svh
// sei_defines.svh: address layout, field positions, erased value and timing for the
// serial eeprom slave. assumes the core clock figure below matches the clock input.
`ifndef SEI_DEFINES_SVH
`define SEI_DEFINES_SVH

// memory geometry
`define SEI_MEM_AW        17
`define SEI_MEM_BYTES     131072
`define SEI_PAGE_AW       9
`define SEI_BYTE_AW       8
`define SEI_ERASED_BYTE   8'hFF

// slave address byte fields, bit 7 first on the wire
`define SEI_SA_DIR_BIT    0
`define SEI_SA_MSB_BIT    1
`define SEI_SA_SEL_LSB    2
`define SEI_SA_SEL_MSB    3
`define SEI_SA_TYPE_LSB   4
`define SEI_SA_TYPE_MSB   7

// bit counter marks: last data bit and acknowledge clock
`define SEI_BIT_LAST      4'h7
`define SEI_BIT_ACK       4'h8

// timing: core clock rate and internal programming time
`define SEI_CLK_MHZ       25
`define SEI_WRITE_TIME_US 5000

`endif

// >>> logic/sei_pkg.sv
// sei_pkg.sv: types shared by the serial eeprom slave.
// assumes nothing of its surroundings.
package sei_pkg;

	// phase of the serial transfer, advanced on rising serial clock
	typedef enum logic [2:0] {
		SEI_PH_IDLE = 3'b000,
		SEI_PH_ADDR = 3'b001,
		SEI_PH_HI   = 3'b010,
		SEI_PH_LO   = 3'b011,
		SEI_PH_WR   = 3'b100,
		SEI_PH_RD   = 3'b101
	} sei_phase_t;

endpackage

// >>> logic/sei_slave.sv
// sei_slave.sv: two-wire slave logic of a 1-Mbit byte-wide nonvolatile memory.
// assumes an external master owns the serial clock, a board-level wire-and resolves
// the data line from sda_oe, and rst_n is the power-on reset.
`timescale 1ns/100ps
`include "sei_defines.svh"

module sei_slave
	import sei_pkg::*;
#(
	parameter int         PROG_CYCLES = `SEI_WRITE_TIME_US * `SEI_CLK_MHZ,
	parameter logic [3:0] DEV_TYPE    = 4'h6 // arbitrary device-type prefix
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic select_pin_low,
	input  wire logic select_pin_high,
	input  wire logic write_protect,
	output logic      write_busy
);

	// start / stop detection, clocked by the data line itself
	logic                   start_tgl_q;
	logic                   stop_tgl_q;
	// serial clock domain
	logic                   start_seen_q;
	logic                   stop_seen_q;
	logic                   busy_s1_q;
	logic                   busy_s2_q;
	sei_phase_t             phase_q;
	logic [3:0]             cnt_q;
	logic [7:0]             shift_q;
	logic [7:0]             tx_q;
	logic [7:0]             hi_q;
	logic                   sa_msb_q;
	logic                   rw_q;
	logic                   ack_q;
	logic                   wr_pend_q;
	logic                   wp_lat_q;
	logic                   sda_oe_q;
	logic                   sda_lvl_q;
	logic [`SEI_MEM_AW-1:0] addr_q;
	logic [`SEI_PAGE_AW-1:0] page_q;
	logic [255:0]           pvalid_q;
	logic [7:0]             pbuf_q [0:255];
	// core clock domain
	logic [1:0]             sel_s1_q;
	logic [1:0]             sel_s2_q;
	logic [1:0]             sel_s3_q;
	logic [1:0]             sel_q;
	logic                   stop_s1_q;
	logic                   stop_s2_q;
	logic                   stop_s3_q;
	logic                   stop_last_q;
	logic                   busy_q;
	logic [31:0]            timer_q;
	logic [8:0]             idx_q;
	logic [7:0]             mem_q [0:`SEI_MEM_BYTES-1]
		= '{default: `SEI_ERASED_BYTE}; // delivered erased

	logic                   start_pend;
	logic                   stop_pend;
	logic                   live;
	logic [7:0]             byte_w;
	logic                   sa_match;
	logic [`SEI_MEM_AW-1:0] addr_nx;
	logic                   stop_evt;

	assign start_pend = start_tgl_q != start_seen_q;
	assign stop_pend  = stop_tgl_q != stop_seen_q;
	assign live       = !start_pend && !stop_pend;
	assign byte_w     = {shift_q[6:0], sda_in};
	assign addr_nx    = addr_q + 17'h0_0001; // wraps to zero past the last byte
	// slave address decode: prefix and select bits, and
	assign sa_match   = (byte_w[`SEI_SA_TYPE_MSB:`SEI_SA_TYPE_LSB] == DEV_TYPE)
		&& (byte_w[`SEI_SA_SEL_MSB:`SEI_SA_SEL_LSB] == sel_q);

	// outputs straight from flip-flops; the line is only ever pulled low
	assign sda_out    = sda_lvl_q;
	assign sda_oe     = sda_oe_q;
	assign write_busy = busy_q;

	// start: data falls while clock high; toggles so the clock domain sees each one
	always_ff @(negedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			start_tgl_q <= 1'b0;
		end else if (scl_in) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// stop: data rises while clock high
	always_ff @(posedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			stop_tgl_q <= 1'b0;
		end else if (scl_in) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// busy level into the serial clock domain, two flops
	always_ff @(posedge scl_in or negedge rst_n) begin
		if (!rst_n) begin
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			busy_s1_q <= busy_q;
			busy_s2_q <= busy_s1_q;
		end
	end

	// transfer control on the rising clock; the toggles are compared directly because
	// the bus guarantees a start hold time of a half period before the next rise
	always_ff @(posedge scl_in or negedge rst_n) begin
		if (!rst_n) begin // power-on state is standby
			start_seen_q <= 1'b0;
			stop_seen_q  <= 1'b0;
			phase_q      <= SEI_PH_IDLE;
			cnt_q        <= 4'h0;
			shift_q      <= 8'h00;
			tx_q         <= 8'h00;
			hi_q         <= 8'h00;
			sa_msb_q     <= 1'b0;
			rw_q         <= 1'b0;
			ack_q        <= 1'b0;
			wr_pend_q    <= 1'b0;
			addr_q       <= 17'h0_0000;
			page_q       <= 9'h000;
			pvalid_q     <= '0;
		end else begin
			start_seen_q <= start_tgl_q;
			stop_seen_q  <= stop_tgl_q;
			if (start_pend) begin // first address bit rides on this rise
				phase_q <= SEI_PH_ADDR;
				cnt_q   <= 4'h1;
				shift_q <= {7'h00, sda_in};
				ack_q   <= 1'b0;
			end else if (stop_pend || phase_q == SEI_PH_IDLE) begin
				phase_q <= SEI_PH_IDLE; // ignore traffic until the next start
				ack_q   <= 1'b0;
			end else if (cnt_q != `SEI_BIT_ACK) begin
				cnt_q <= cnt_q + 4'h1;
				if (phase_q == SEI_PH_RD) begin
					tx_q <= {tx_q[6:0], 1'b0};
				end else begin
					shift_q <= byte_w; // sampled on the rise
				end
				if (cnt_q == `SEI_BIT_LAST) begin
					case (phase_q)
						SEI_PH_ADDR: begin
							// no answer while programming
							ack_q     <= sa_match && !busy_s2_q;
							rw_q      <= byte_w[`SEI_SA_DIR_BIT];
							sa_msb_q  <= byte_w[`SEI_SA_MSB_BIT];
							wr_pend_q <= 1'b0;
						end
						SEI_PH_HI: begin
							ack_q <= 1'b1;
							hi_q  <= byte_w;
						end
						SEI_PH_LO: begin
							ack_q    <= 1'b1;
							addr_q   <= {sa_msb_q, hi_q, byte_w};
							page_q   <= {sa_msb_q, hi_q};
							pvalid_q <= '0;
						end
						SEI_PH_WR: begin
							ack_q <= !wp_lat_q; // protected write refused
							if (!wp_lat_q) begin
								pvalid_q[addr_q[7:0]] <= 1'b1;
								wr_pend_q             <= 1'b1;
								addr_q[7:0]           <= addr_q[7:0] + 8'h01;
							end
						end
						default: begin
							ack_q <= 1'b0;
						end
					endcase
				end
			end else begin
				// acknowledge clock: move to the next byte or fall idle
				cnt_q <= 4'h0;
				ack_q <= 1'b0;
				case (phase_q)
					SEI_PH_ADDR: begin
						if (!ack_q) begin
							phase_q <= SEI_PH_IDLE;
						end else if (rw_q) begin
							phase_q <= SEI_PH_RD;
							tx_q    <= mem_q[addr_q]; // byte at the counter
						end else begin
							phase_q <= SEI_PH_HI;
						end
					end
					SEI_PH_HI: phase_q <= SEI_PH_LO;
					SEI_PH_LO: phase_q <= SEI_PH_WR;
					SEI_PH_WR: phase_q <= ack_q ? SEI_PH_WR : SEI_PH_IDLE;
					SEI_PH_RD: begin
						addr_q <= addr_nx; // counter points past the byte sent
						if (!sda_in) begin
							tx_q <= mem_q[addr_nx]; // master acknowledged
						end else begin
							phase_q <= SEI_PH_IDLE;
						end
					end
					default: phase_q <= SEI_PH_IDLE;
				endcase
			end
		end
	end

	// page buffer, loaded in place so later bytes replace earlier ones
	always_ff @(posedge scl_in) begin
		if (live && phase_q == SEI_PH_WR && cnt_q == `SEI_BIT_LAST && !wp_lat_q) begin
			pbuf_q[addr_q[7:0]] <= byte_w;
		end
	end

	// data line drive and write-protect strobe on the falling clock
	always_ff @(negedge scl_in or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_q  <= 1'b0;
			sda_lvl_q <= 1'b0;
			wp_lat_q  <= 1'b0;
		end else begin
			sda_lvl_q <= 1'b0;
			if (phase_q == SEI_PH_RD && cnt_q != `SEI_BIT_ACK) begin
				sda_oe_q <= ~tx_q[7]; // change after the fall
			end else if (cnt_q == `SEI_BIT_ACK && ack_q) begin
				sda_oe_q <= 1'b1; // acknowledge low
			end else begin
				sda_oe_q <= 1'b0; // released, also on the read ninth clock
			end
			// fall that ends the low address acknowledge, before any data byte is loaded
			if (phase_q == SEI_PH_WR && cnt_q == 4'h0 && !wr_pend_q) begin
				wp_lat_q <= write_protect; // last fall before first data byte
			end
		end
	end

	// select straps: three flops, taken once the second and third agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_s1_q <= 2'h0;
			sel_s2_q <= 2'h0;
			sel_s3_q <= 2'h0;
			sel_q    <= 2'h0;
		end else begin
			sel_s1_q <= {select_pin_high, select_pin_low};
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			if (sel_s2_q == sel_s3_q) begin
				sel_q <= sel_s3_q;
			end
		end
	end

	// stop toggle into the core domain, the same three-flop filter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stop_s1_q   <= 1'b0;
			stop_s2_q   <= 1'b0;
			stop_s3_q   <= 1'b0;
			stop_last_q <= 1'b0;
		end else begin
			stop_s1_q <= stop_tgl_q;
			stop_s2_q <= stop_s1_q;
			stop_s3_q <= stop_s2_q;
			if (stop_s2_q == stop_s3_q) begin
				stop_last_q <= stop_s3_q;
			end
		end
	end

	assign stop_evt = (stop_s2_q == stop_s3_q) && (stop_s3_q != stop_last_q);

	// programming cycle: write flag is sampled only while idle, since any address byte, a poll included, clears it during busy
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_q  <= 1'b0;
			timer_q <= 32'h0000_0000;
			idx_q   <= 9'h000;
		end else if (!busy_q) begin
			if (stop_evt && wr_pend_q) begin
				busy_q  <= 1'b1;
				timer_q <= 32'h0000_0000;
				idx_q   <= 9'h000;
			end
		end else begin
			if (!idx_q[8]) begin
				idx_q <= idx_q + 9'h001;
			end
			if (timer_q == 32'(PROG_CYCLES - 1)) begin
				busy_q <= 1'b0; // busy for the whole interval
			end else begin
				timer_q <= timer_q + 32'h0000_0001;
			end
		end
	end

	// array commit, one buffered byte per core clock
	always_ff @(posedge clock) begin
		if (busy_q && !idx_q[8] && pvalid_q[idx_q[7:0]]) begin
			mem_q[{page_q, idx_q[7:0]}] <= pbuf_q[idx_q[7:0]];
		end
	end

	// checks in the serial clock domain
	a_start_restart: assert property (@(posedge scl_in) disable iff (!rst_n)
		start_pend |=> phase_q == SEI_PH_ADDR && cnt_q == 4'h1)
		else $error("start did not restart the address byte");
	a_busy_nack: assert property (@(posedge scl_in) disable iff (!rst_n)
		live && phase_q == SEI_PH_ADDR && cnt_q == `SEI_BIT_LAST && busy_s2_q |=> !ack_q)
		else $error("address acknowledged while programming");
	a_addr_match: assert property (@(posedge scl_in) disable iff (!rst_n)
		live && phase_q == SEI_PH_ADDR && cnt_q == `SEI_BIT_LAST && !busy_s2_q
		|=> ack_q == $past(sa_match))
		else $error("address acknowledge does not follow the match");
	a_ack_driven: assert property (@(posedge scl_in) disable iff (!rst_n)
		cnt_q == `SEI_BIT_ACK && ack_q && phase_q != SEI_PH_IDLE |-> sda_oe_q)
		else $error("acknowledge not driven on ninth clock");
	a_read_release: assert property (@(posedge scl_in) disable iff (!rst_n)
		phase_q == SEI_PH_RD && cnt_q == `SEI_BIT_ACK |-> !sda_oe_q)
		else $error("data line held during read acknowledge");
	a_wp_reject: assert property (@(posedge scl_in) disable iff (!rst_n)
		live && phase_q == SEI_PH_WR && cnt_q == `SEI_BIT_LAST && wp_lat_q
		|=> !ack_q && $stable(pvalid_q))
		else $error("protected write accepted");
	a_page_wrap: assert property (@(posedge scl_in) disable iff (!rst_n)
		live && phase_q == SEI_PH_WR && cnt_q == `SEI_BIT_LAST && !wp_lat_q
		|=> addr_q[7:0] == $past(addr_q[7:0]) + 8'h01 && $stable(addr_q[16:8]))
		else $error("page write counter left its page");
	a_read_step: assert property (@(posedge scl_in) disable iff (!rst_n)
		live && phase_q == SEI_PH_RD && cnt_q == `SEI_BIT_ACK
		|=> addr_q == $past(addr_q) + 17'h0_0001)
		else $error("read address did not step");
	// checks in the core clock domain
	a_prog_start: assert property (@(posedge clock) disable iff (!rst_n)
		!busy_q && stop_evt && wr_pend_q |=> busy_q [*4])
		else $error("stop after write did not start programming");
	a_read_no_prog: assert property (@(posedge clock) disable iff (!rst_n)
		!busy_q && stop_evt && !wr_pend_q |=> !busy_q)
		else $error("programming started without a write");
	a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
		busy_q && timer_q != 32'(PROG_CYCLES - 1) |=> busy_q)
		else $error("busy ended before the programming time");

	c_write_ack: cover property (@(posedge scl_in) disable iff (!rst_n)
		phase_q == SEI_PH_WR && cnt_q == `SEI_BIT_ACK && ack_q);
	c_seq_read: cover property (@(posedge scl_in) disable iff (!rst_n)
		phase_q == SEI_PH_RD && cnt_q == `SEI_BIT_ACK && !sda_in);
	c_wp_reject: cover property (@(posedge scl_in) disable iff (!rst_n)
		phase_q == SEI_PH_WR && wp_lat_q);
	c_poll_nack: cover property (@(posedge scl_in) disable iff (!rst_n)
		phase_q == SEI_PH_ADDR && cnt_q == `SEI_BIT_ACK && busy_s2_q);

endmodule

// >>> verif/sei_master_model.sv
// sei_master_model.sv: behavioural two-wire bus master that makes clock and conditions.
// assumes a pull-up on the data line; sda_rel high means the master lets it float.
`timescale 1ns/100ps

module sei_master_model (
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda
);
	int half = 24; // half of the 48 ns link period; raise it for a slow master

	// idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_rel = 1'b1;
		#(half / 2) scl = 1'b1;
		#(half / 2) sda_rel = 1'b0;
		#half scl = 1'b0;
	endtask

	// stop: data rises while the clock is high, then the clock stands still
	task automatic stop();
		#(half / 2) sda_rel = 1'b0;
		#(half / 2) scl = 1'b1;
		#half sda_rel = 1'b1;
		#half;
	endtask

	// one bit: data only moves while the clock is low, sampled mid-high
	task automatic bit_io(input logic v, output logic r);
		if (scl) scl = 1'b0; // only lower a clock that stands high
		#(half / 2) sda_rel = v;
		#(half / 2) scl = 1'b1;
		#(half / 2) r = sda;
		#(half / 2) scl = 1'b0;
	endtask

	// byte out, msb first, then release for the slave acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// byte in, then acknowledge to go on or release to end the read
	task automatic recv(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

// >>> verif/sei_slave_tb_top.sv
// sei_slave_tb_top.sv: self-checking bench of the serial eeprom slave against a byte model.
// assumes the master model drives the link and a pull-up resolves the data line.
`timescale 1ns/100ps
`include "sei_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end

module sei_slave_tb_top;
	import sei_pkg::*;
	localparam int         PC = 300;
	localparam logic [3:0] DT = 4'h6; // arbitrary device-type prefix
	logic       clock;
	logic       rst_n;
	logic       select_pin_low;
	logic       select_pin_high;
	logic       write_protect;
	logic [1:0] sel;
	wire        scl;
	wire        sda_rel;
	wire        sda;
	logic       sda_out;
	logic       sda_oe;
	logic       write_busy;
	logic [7:0] mem [int];
	int         ctr;
	int         busy_len;
	int         cyc;
	int         err_count;
	int         check_count;

	// wire-and of master release and device pull-down
	assign sda = sda_rel & ~(sda_oe & ~sda_out);

	sei_slave #(.PROG_CYCLES(PC), .DEV_TYPE(DT)) dut (
		.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .select_pin_low(select_pin_low), .select_pin_high(select_pin_high),
		.write_protect(write_protect), .write_busy(write_busy));
	sei_master_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda));

	// core clock and hang guard
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (write_busy === 1'b1) busy_len++;
		if (cyc == 40000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// model byte, erased unless written
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : `SEI_ERASED_BYTE;
	endfunction

	task automatic set_pins(input logic [1:0] s, input logic w);
		@(negedge clock);
		{select_pin_high, select_pin_low} = s;
		write_protect = w;
		sel = s;
		repeat (4) @(negedge clock);
	endtask

	task automatic addr_ph(input int a, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		m.start();
		m.send({DT, sel, a[16], 1'b0}, k0);
		m.send(a[15:8], k1);
		m.send(a[7:0], k2);
		ok = k0 & k1 & k2;
	endtask

	task automatic poll(input logic exp);
		logic ok;
		m.start();
		m.send({DT, sel, 2'b00}, ok);
		m.stop();
		`CHK("poll ack", exp, ok)
	endtask

	task automatic do_write(input int a, input int n);
		logic ok;
		logic [7:0] d;
		int pg;
		addr_ph(a, ok);
		`CHK("addr ack", 1'b1, ok)
		pg = a & 32'h0001_FF00;
		for (int i = 0; i < n && !(write_protect && i > 0); i++) begin
			d = 8'($urandom);
			m.send(d, ok);
			`CHK("data ack", ~write_protect, ok)
			if (!write_protect) mem[pg | ((a + i) & 32'h0000_00FF)] = d;
		end
		busy_len = 0;
		m.stop();
		if (write_protect) begin
			repeat (20) @(negedge clock);
			`CHK("no prog", 1'b0, write_busy)
		end else begin
			ctr = pg | ((a + n) & 32'h0000_00FF);
			repeat (20) @(negedge clock);
			`CHK("busy rise", 1'b1, write_busy)
			poll(1'b0);
			for (int k = 0; k < PC + 50 && write_busy !== 1'b0; k++) @(negedge clock);
			`CHK("busy len", 1'b1, busy_len >= PC && busy_len <= PC + 1)
			poll(1'b1);
		end
	endtask

	task automatic do_read(input int a, input int n, input bit s);
		logic ok;
		logic [7:0] b;
		if (s) begin
			addr_ph(a, ok);
			`CHK("dummy ack", 1'b1, ok)
			ctr = a;
		end
		m.start();
		m.send({DT, sel, 2'b01}, ok);
		`CHK("read ack", 1'b1, ok)
		for (int i = 0; i < n; i++) begin
			m.recv(i == n - 1, b);
			`CHK("read data", rd(ctr), b)
			ctr = (ctr + 1) % `SEI_MEM_BYTES;
		end
		m.stop();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// main sequence
	initial begin
		int a;
		logic ok;
		rst_n = 1'b0;
		{select_pin_high, select_pin_low, write_protect, sel} = 5'h00;
		void'($urandom(32'hB3D5_4D23));
		repeat (16) @(posedge clock);
		`CHK("oe in reset", 1'b0, sda_oe)
		@(negedge clock) rst_n = 1'b1;
		repeat (4) @(negedge clock);
		`CHK("busy idle", 1'b0, write_busy)
		m.send({DT, sel, 2'b00}, ok);
		m.stop();
		`CHK("no start", 1'b0, ok)
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			set_pins(2'(s), 1'b0);
			a = $urandom_range(32'h0001_FFFF);
			do_write(a, 1);
			do_read(a, 1, 1);
			m.start();
			m.send({DT, ~sel, 2'b00}, ok);
			m.stop();
			`CHK("bad select", 1'b0, ok)
			m.start();
			m.send({~DT, sel, 2'b00}, ok);
			m.stop();
			`CHK("bad prefix", 1'b0, ok)
		end
		$display("test straps done");
		a = ($urandom_range(32'h0000_01FF) << 8) | 32'h0000_00FE;
		do_write(a, 258);
		do_read(0, 3, 0);
		do_read(a & 32'h0001_FF00, 4, 1);
		$display("test page done");
		do_write(32'h0001_FFFF, 1);
		do_read(32'h0001_FFFE, 4, 1);
		$display("test wrap done");
		set_pins(sel, 1'b1);
		a = $urandom_range(32'h0001_FFFF);
		do_write(a, 2);
		set_pins(sel, 1'b0);
		do_read(a, 1, 1);
		$display("test protect done");
		tally_and_finish();
	end
endmodule
